// *** ptc_pkg.sv ***
// package: constants, states and carrier structs for the pci target control block
package ptc_pkg;
  localparam logic [3:0] PTC_CMD_SPECIAL = 4'h1;
  localparam logic [3:0] PTC_CMD_CFG_RD = 4'ha;
  localparam logic [3:0] PTC_CMD_CFG_WR = 4'hb;
  localparam logic [3:0] PTC_CMD_IO_RD = 4'h2;
  localparam logic [3:0] PTC_CMD_IO_WR = 4'h3;
  localparam logic [3:0] PTC_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PTC_CMD_MEM_WR = 4'h7;
  localparam int PTC_PERR_DELAY = 2; // clocks from detection to perr assertion
  localparam int PTC_PERR_HOLD = 2; // clocks driven high before release
  localparam logic [1:0] PTC_CNT_W2 = 2'h2;

  typedef enum logic [2:0] {
    PTC_IDLE,
    PTC_DATA,
    PTC_TURN,
    PTC_BUSY
  } ptc_state_t;

  // bus control inputs from the initiator
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic idsel;
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic par;
  } ptc_bus_in_t;

  // target control outputs with enables
  typedef struct packed {
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic ctl_oe;
    logic perr_n;
    logic perr_oe;
    logic serr_n;
    logic serr_oe;
  } ptc_bus_out_t;
endpackage : ptc_pkg

// *** ptc_parity.sv ***
// module: even parity over address/data and byte enables
`timescale 1ns/10ps
module ptc_parity
  import ptc_pkg::*;
(
  input wire logic [31:0] ad_in,
  input wire logic [3:0] cbe_n_in,
  output logic par_out
);
  // even parity so that ad, cbe and par together hold an even count of ones
  assign par_out = ^{ad_in, cbe_n_in};
endmodule : ptc_parity

// *** ptc_target_ctl.sv ***
// module: pci target control signalling (trdy, stop, devsel, perr, serr, inta)
//
// Summary of operation
// - trdy only when data phase can complete
// - phase completes when trdy and irdy both low
// - stop asks master to end transaction
// - idsel selects configuration cycles
// - devsel asserted after decoding own cycle
// - perr two clocks after data parity error
// - perr driven high two clocks before release
// - serr for address or special parity errors
// - inta level low while interrupt pending
// - all bus inputs sampled on rising clock
// - par is even parity, one clock late
`timescale 1ns/10ps
module ptc_target_ctl
  import ptc_pkg::*;
#(
  parameter int ADDR_HI_W = 20
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire ptc_bus_in_t bus_in,
  input wire logic [ADDR_HI_W-1:0] mem_base_in,
  input wire logic ready_in,
  input wire logic stop_req_in,
  input wire logic fatal_in,
  input wire logic irq_pending_in,
  output ptc_bus_out_t bus_out,
  output logic data_done_out,
  output logic cfg_cycle_out,
  output logic rd_cycle_out,
  output logic inta_n_out
);

  // refuse decode widths that the address field cannot hold
  if (ADDR_HI_W < 1 || ADDR_HI_W > 31) begin : g_bad_width
    $error("ADDR_HI_W out of range");
  end

  typedef struct packed {
    ptc_state_t st;
    logic trdy;
    logic stop;
    logic devsel;
    logic ctl_oe;
    logic is_rd;
    logic is_cfg;
    logic special;
    logic chk_addr;
    logic chk_data;
    logic chk_special;
    logic [31:0] prev_ad;
    logic [3:0] prev_cbe;
    logic perr_pend;
    logic perr;
    logic perr_oe;
    logic [1:0] perr_hold;
    logic serr;
    logic inta;
  } ptc_regs_t;

  ptc_regs_t r_q;
  ptc_regs_t r_d;
  logic calc_par;
  logic par_bad;
  logic addr_phase;
  logic hit;
  logic done;
  logic [3:0] cmd;

  ptc_parity u_parity (
    .ad_in(r_q.prev_ad),
    .cbe_n_in(r_q.prev_cbe),
    .par_out(calc_par)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of the sampled address phase
  assign cmd = bus_in.cbe_n; // command code stands on cbe_n as is
  assign addr_phase = (r_q.st == PTC_IDLE) && !bus_in.frame_n;
  assign par_bad = (calc_par != bus_in.par);
  assign done = r_q.trdy && !bus_in.irdy_n;
  always_comb begin
    hit = 1'b0;
    if ((cmd == PTC_CMD_CFG_RD || cmd == PTC_CMD_CFG_WR) && bus_in.idsel) begin
      hit = 1'b1;
    end else if ((cmd == PTC_CMD_MEM_RD || cmd == PTC_CMD_MEM_WR) &&
                 bus_in.ad[31 -: ADDR_HI_W] == mem_base_in) begin
      hit = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_d = r_q;
    r_d.prev_ad = bus_in.ad;
    r_d.prev_cbe = bus_in.cbe_n;
    r_d.chk_addr = 1'b0;
    r_d.chk_data = 1'b0;
    r_d.chk_special = 1'b0;
    r_d.serr = 1'b0;
    r_d.inta = irq_pending_in;
    case (r_q.st)
      PTC_IDLE: begin
        r_d.chk_addr = addr_phase;
        if (addr_phase) begin
          r_d.special = (cmd == PTC_CMD_SPECIAL);
          if (hit) begin
            r_d.st = PTC_DATA;
            r_d.devsel = 1'b1;
            r_d.ctl_oe = 1'b1;
            r_d.is_rd = !cmd[0];
            r_d.is_cfg = cmd[3];
          end else begin
            r_d.st = PTC_BUSY;
          end
        end
      end
      PTC_DATA: begin
        r_d.trdy = ready_in && !stop_req_in;
        r_d.stop = stop_req_in || (r_q.stop && !bus_in.frame_n);
        r_d.chk_data = done && !r_q.is_rd;
        if ((done || (r_q.stop && !bus_in.irdy_n)) && bus_in.frame_n) begin
          r_d.st = PTC_TURN;
          r_d.trdy = 1'b0;
          r_d.stop = 1'b0;
          r_d.devsel = 1'b0;
        end else if (done && r_q.stop) begin
          r_d.trdy = 1'b0;
        end
      end
      PTC_TURN: begin
        r_d.ctl_oe = 1'b0;
        r_d.st = PTC_IDLE;
      end
      default: begin
        // foreign or special cycle: watch it for special-cycle data parity
        r_d.chk_special = r_q.special && !bus_in.irdy_n;
        if (bus_in.frame_n && !bus_in.irdy_n) begin
          r_d.st = PTC_IDLE;
        end
      end
    endcase
    // parity checks one clock after the protected phase
    r_d.perr_pend = r_q.chk_data && par_bad;
    if (r_q.perr_pend) begin
      r_d.perr = 1'b1;
      r_d.perr_oe = 1'b1;
      r_d.perr_hold = PTC_CNT_W2;
    end else if (r_q.perr) begin
      r_d.perr = 1'b0;
    end else if (r_q.perr_hold == 2'h1) begin
      r_d.perr_oe = 1'b0;
      r_d.perr_hold = 2'h0;
    end else if (r_q.perr_hold != 2'h0) begin
      r_d.perr_hold = r_q.perr_hold - 2'h1;
    end
    if ((r_q.chk_addr || r_q.chk_special) && par_bad) begin
      r_d.serr = 1'b1;
    end
    if (fatal_in) begin
      r_d.serr = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins
  assign bus_out.trdy_n = !r_q.trdy;
  assign bus_out.stop_n = !r_q.stop;
  assign bus_out.devsel_n = !r_q.devsel;
  assign bus_out.ctl_oe = r_q.ctl_oe;
  assign bus_out.perr_n = !r_q.perr;
  assign bus_out.perr_oe = r_q.perr_oe;
  assign bus_out.serr_n = !r_q.serr;
  assign bus_out.serr_oe = r_q.serr; // open drain
  assign data_done_out = done;
  assign cfg_cycle_out = r_q.is_cfg;
  assign rd_cycle_out = r_q.is_rd;
  assign inta_n_out = !r_q.inta;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_err_seen;
    r_q.chk_data && par_bad;
  endsequence
  property p_perr_delay;
    @(posedge clk_in) disable iff (!resetn_in)
      s_err_seen |=> ##1 (!bus_out.perr_n && bus_out.perr_oe);
  endproperty
  a_perr_delay: assert property (p_perr_delay) else $error("perr late");
  property p_perr_release;
    @(posedge clk_in) disable iff (!resetn_in)
      ($fell(bus_out.perr_oe)) |-> $past(bus_out.perr_n, 1) && $past(bus_out.perr_n, 2);
  endproperty
  a_perr_release: assert property (p_perr_release) else $error("perr release");
  property p_trdy_ready;
    @(posedge clk_in) disable iff (!resetn_in)
      $fell(bus_out.trdy_n) |-> $past(ready_in);
  endproperty
  a_trdy_ready: assert property (p_trdy_ready) else $error("trdy not ready");
  property p_trdy_sel;
    @(posedge clk_in) disable iff (!resetn_in)
      !bus_out.trdy_n |-> !bus_out.devsel_n && bus_out.ctl_oe;
  endproperty
  a_trdy_sel: assert property (p_trdy_sel) else $error("trdy unselected");
  property p_stop;
    @(posedge clk_in) disable iff (!resetn_in)
      (stop_req_in && r_q.st == PTC_DATA) |=> !bus_out.stop_n || r_q.st == PTC_TURN;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missing");
  property p_cfg_idsel;
    @(posedge clk_in) disable iff (!resetn_in)
      (addr_phase && cmd == PTC_CMD_CFG_RD && !bus_in.idsel) |=> bus_out.devsel_n;
  endproperty
  a_cfg_idsel: assert property (p_cfg_idsel) else $error("cfg without idsel");
  property p_devsel;
    @(posedge clk_in) disable iff (!resetn_in)
      (addr_phase && hit) |=> !bus_out.devsel_n;
  endproperty
  a_devsel: assert property (p_devsel) else $error("devsel missing");
  property p_serr;
    @(posedge clk_in) disable iff (!resetn_in)
      fatal_in |=> !bus_out.serr_n && bus_out.serr_oe;
  endproperty
  a_serr: assert property (p_serr) else $error("serr missing");
  property p_inta;
    @(posedge clk_in) disable iff (!resetn_in)
      irq_pending_in |=> !inta_n_out;
  endproperty
  a_inta: assert property (p_inta) else $error("inta missing");
  property p_release;
    @(posedge clk_in) disable iff (!resetn_in)
      $fell(bus_out.ctl_oe) |-> $past(bus_out.devsel_n) && $past(bus_out.trdy_n);
  endproperty
  a_release: assert property (p_release) else $error("release while active");
endmodule : ptc_target_ctl

// *** ptc_master.sv ***
// initiator model driving the target's bus inputs
`timescale 1ns/10ps
module ptc_master
  import ptc_pkg::*;
(
  input wire logic clk_in,
  input wire ptc_bus_out_t tgt_in,
  output ptc_bus_in_t bus_out
);
  initial bus_out = '{1'b1, 1'b1, 1'b0, 32'h0, 4'hf, 1'b0};
  // one-phase transfer; bad[0] spoils address parity, bad[1] data parity
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] adr, input logic sel,
      input logic [1:0] bad, output logic hit, output logic stp);
    int n;
    hit = 1'b0;
    stp = 1'b0;
    n = 0;
    @(posedge clk_in);
    bus_out <= '{1'b0, 1'b1, sel, adr, cmd, bus_out.par};
    @(posedge clk_in);
    bus_out <= '{1'b1, 1'b0, 1'b0, ~adr, 4'h0, ^{adr, cmd} ^ bad[0]};
    // hold irdy until trdy or stop; give up as master abort
    do begin
      @(posedge clk_in);
      // write data parity follows irdy by one clock
      if (n == 0) bus_out.par <= ^{~adr, 4'h0} ^ bad[1];
      hit |= !tgt_in.devsel_n && tgt_in.ctl_oe;
      stp |= !tgt_in.stop_n && tgt_in.ctl_oe;
      n++;
    end while (!(tgt_in.ctl_oe && !(tgt_in.trdy_n && tgt_in.stop_n)) && n < 12);
    // released lines: pull-ups high, ad back to adr
    bus_out <= '{1'b1, 1'b1, 1'b0, adr, 4'hf, ^{~adr, 4'h0} ^ bad[1]};
  endtask : xfer
endmodule : ptc_master

// *** ptc_target_ctl_bench.sv ***
// self-checking bench for the pci target control block
`timescale 1ns/10ps
module ptc_target_ctl_bench
  import ptc_pkg::*;
;
  logic clk_in = 1'b0, resetn_in = 1'b0, ready_in = 1'b0, stop_req_in = 1'b0;
  logic fatal_in = 1'b0, irq_pending_in = 1'b0, rst_p = 1'b0, rdy_p = 1'b0, irq_p = 1'b0;
  logic data_done_out, cfg_cycle_out, rd_cycle_out, inta_n_out, hit, stp, sel;
  logic [1:0] done_p = 2'h0;
  logic [1:0] kind_q = 2'h0;
  logic [3:0] cmd = 4'h0;
  logic [31:0] lfsr_q = 32'hfb2d0c84;
  logic [19:0] base_c = 20'h3a5c1;
  logic [3:0] cmds [4] = '{PTC_CMD_CFG_RD, PTC_CMD_CFG_WR, PTC_CMD_MEM_RD, PTC_CMD_MEM_WR};
  int errors = 0, n_tests = 0, cyc = 0, done_cyc = 0, perr_cyc = 0, hold_cnt = 0, serr_cnt = 0;
  ptc_bus_in_t bus_in;
  ptc_bus_out_t bus_out;

  ptc_target_ctl #(.ADDR_HI_W(20)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .bus_in(bus_in), .mem_base_in(base_c), .ready_in(ready_in), .stop_req_in(stop_req_in),
    .fatal_in(fatal_in), .irq_pending_in(irq_pending_in), .bus_out(bus_out),
    .data_done_out(data_done_out), .cfg_cycle_out(cfg_cycle_out),
    .rd_cycle_out(rd_cycle_out), .inta_n_out(inta_n_out));
  ptc_master i_mst (.clk_in(clk_in), .tgt_in(bus_out), .bus_out(bus_in));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr_next

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // random back end, per-cycle checks, timeout
  always @(posedge clk_in) begin
    lfsr_q <= lfsr_next(lfsr_q);
    ready_in <= lfsr_q[0] | lfsr_q[1];
    irq_pending_in <= lfsr_q[5] ? lfsr_q[9] : irq_pending_in;
    rdy_p <= ready_in & ~stop_req_in;
    irq_p <= irq_pending_in;
    rst_p <= resetn_in;
    done_p <= {done_p[0], data_done_out};
    // expected kind from the command seen in the address phase
    if (!bus_in.frame_n) kind_q <= {bus_in.cbe_n[3], !bus_in.cbe_n[0]};
    cyc <= cyc + 1;
    if (rst_p && resetn_in) begin
      check("done", data_done_out, bus_out.ctl_oe & !bus_out.trdy_n & !bus_in.irdy_n);
      check("inta", inta_n_out, !irq_p);
      if (bus_out.ctl_oe && !bus_out.trdy_n) check("trdy", rdy_p, 1);
      if (bus_out.ctl_oe && !bus_out.devsel_n) check("kind", {cfg_cycle_out, rd_cycle_out},
          kind_q);
      if (done_p[0]) check("rel1", {bus_out.devsel_n, bus_out.trdy_n, bus_out.ctl_oe}, 7);
      if (done_p[1]) check("rel2", bus_out.ctl_oe, 0);
      if (data_done_out) done_cyc = cyc;
      if (bus_out.perr_oe && !bus_out.perr_n && perr_cyc == 0) perr_cyc = cyc;
      if (bus_out.perr_oe && bus_out.perr_n) hold_cnt++;
      if (bus_out.serr_oe && !bus_out.serr_n) serr_cnt++;
    end
    if (cyc > 6000) begin
      errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    // each config and memory command, claimed or not by select line or address
    for (int i = 0; i < 16; i++) begin
      cmd = cmds[i % 4];
      sel = lfsr_q[3];
      i_mst.xfer(cmd, {sel ? base_c : ~base_c, lfsr_q[11:0]}, sel, 2'h0, hit, stp);
      check("claim", hit, sel);
    end
    // target stop mid transfer
    stop_req_in <= 1'b1;
    cmd = PTC_CMD_MEM_RD;
    i_mst.xfer(cmd, {base_c, 12'h040}, 1'b0, 2'h0, hit, stp);
    check("stop", stp, 1);
    stop_req_in <= 1'b0;
    // bad write data parity
    perr_cyc = 0;
    hold_cnt = 0;
    cmd = PTC_CMD_MEM_WR;
    i_mst.xfer(cmd, {base_c, 12'hffc}, 1'b0, 2'h2, hit, stp);
    repeat (8) @(posedge clk_in);
    check("perr_at", perr_cyc - done_cyc, PTC_PERR_DELAY + 1);
    check("perr_hold", hold_cnt, PTC_PERR_HOLD);
    // bad address parity on a claimed memory write
    serr_cnt = 0;
    i_mst.xfer(cmd, {base_c, 12'h000}, 1'b0, 2'h1, hit, stp);
    repeat (4) @(posedge clk_in);
    // special cycle with bad data parity: serr, no perr, not claimed
    perr_cyc = 0;
    cmd = PTC_CMD_SPECIAL;
    i_mst.xfer(cmd, lfsr_q, 1'b0, 2'h2, hit, stp);
    check("special_claim", hit, 0);
    repeat (4) @(posedge clk_in);
    check("special_perr", perr_cyc, 0);
    fatal_in <= 1'b1;
    @(posedge clk_in);
    fatal_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check("serr", serr_cnt, 3);
    print_verdict();
  end
endmodule : ptc_target_ctl_bench
